/* File: tb_top.sv */
// Testbench for the VLAN port tagging framer
`timescale 1ns/1ps
module tb_top;
  import vpt_pkg::*;
  logic        i_clk, i_nrst, i_wr, i_rd, i_in_valid, i_in_sof, i_in_eof, i_in_mgmt, slow;
  logic [7:0]  i_addr, i_in_data, o_out_data;
  logic [31:0] i_wdata, o_rdata;
  logic [1:0]  i_in_src, i_in_dst, o_out_port;
  logic        o_in_ready, o_out_valid, i_out_ready, o_out_sof, o_out_eof, o_out_err;
  logic        o_mode_q, o_gvrp_en;
  int          fails, compares, cyc;
  logic [7:0]  fr[$], ex[$];

  vpt_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_in_valid(i_in_valid),
    .o_in_ready(o_in_ready), .i_in_data(i_in_data), .i_in_sof(i_in_sof), .i_in_eof(i_in_eof),
    .i_in_src(i_in_src), .i_in_dst(i_in_dst), .i_in_mgmt(i_in_mgmt),
    .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_data(o_out_data),
    .o_out_sof(o_out_sof), .o_out_eof(o_out_eof), .o_out_err(o_out_err),
    .o_out_port(o_out_port), .o_mode_q(o_mode_q), .o_gvrp_en(o_gvrp_en));
  vpt_station u_sta (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(o_out_valid),
    .i_data(o_out_data), .i_eof(o_out_eof), .i_err(o_out_err), .i_sof(o_out_sof),
    .i_port(o_out_port), .i_slow(slow),
    .o_ready(i_out_ready));
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic results();
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    check(nm, o_rdata, e);
  endtask
  task automatic mk(input logic [31:0] t);
    fr.delete();
    for (int i = 0; i < 12; i++) fr.push_back(8'(i + 1));
    for (int i = 3; i >= 0; i--) fr.push_back(t[8*i +: 8]);
    fr.push_back(8'h5a);
    fr.push_back(8'ha5);
  endtask
  // Send fr from port s to port d, then compare what the station got with ex
  task automatic xfer(input logic [1:0] s, input logic [1:0] d, input logic e_err);
    int   n;
    logic r;
    n = u_sta.frames;
    @(posedge i_clk);
    for (int i = 0; i < fr.size(); i++) begin
      i_in_valid <= 1'b1;
      i_in_data  <= fr[i];
      i_in_sof   <= (i == 0);
      i_in_eof   <= (i == fr.size() - 1);
      i_in_src   <= s;
      i_in_dst   <= d;
      do begin
        @(negedge i_clk);
        r = o_in_ready;
        @(posedge i_clk);
      end while (!r);
    end
    i_in_valid <= 1'b0;
    for (int k = 0; k < 300 && u_sta.frames == n; k++) @(posedge i_clk);
    check("frame err", 32'(u_sta.got_err), 32'(e_err));
    check("frame length", u_sta.q.size(), ex.size());
    check("frame sof", u_sta.sofs, 1);
    check("frame port", 32'(u_sta.port), 32'(d));
    u_sta.sofs = 0;
    foreach (ex[i]) check("frame byte", 32'(u_sta.q[i]), 32'(ex[i]));
    u_sta.q.delete();
    u_sta.got_err = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rdc("ctrl busy", VPT_REG_CTRL, 32'h0000_0005);
    check("ready in sweep", 32'(o_in_ready), 32'h0);
    for (int k = 0; k < 5000 && !o_in_ready; k++) @(posedge i_clk);
    rdc("ctrl", VPT_REG_CTRL, 32'h0000_0001);
    rdc("port0", VPT_REG_PORT_BASE, 32'h0001_0f00);
    rdc("unmapped", 8'h80, 32'h0000_0000);
  endtask
  task automatic t_mode();
    wr(8'h14, 32'h0009_0f00);
    wr(VPT_REG_CTRL, 32'h0000_0002);
    @(negedge i_clk);
    check("gvrp", 32'({o_mode_q, o_gvrp_en}), 32'h0);
    wr(VPT_REG_CTRL, 32'h0000_0003);
    @(negedge i_clk);
    check("gvrp", 32'({o_mode_q, o_gvrp_en}), 32'h3);
    rdc("port1", 8'h14, 32'h0001_0f00);
    wr(VPT_REG_CTRL, 32'h0000_0001);
  endtask
  task automatic t_regs();
    wr(VPT_REG_PORT_BASE, 32'h0000_0f02);
    rdc("port_default_vlan_id zero", VPT_REG_PORT_BASE, 32'h0001_0f02);
    wr(VPT_REG_PORT_BASE, 32'h0fff_0f00);
    rdc("port_default_vlan_id max", VPT_REG_PORT_BASE, 32'h0001_0f00);
    wr(VPT_REG_PORT_BASE, 32'h0001_0f03);
    rdc("type rsvd", VPT_REG_PORT_BASE, 32'h0001_0f00);
    wr(8'h14, 32'h0009_0f01);
    rdc("trunk port_default_vlan_id", 8'h14, 32'h0001_0f01);
  endtask
  task automatic vt(input logic [11:0] v, input logic [3:0] m);
    wr(VPT_REG_VT_ADDR, 32'(v));
    wr(VPT_REG_VT_DATA, 32'(m));
  endtask
  task automatic t_frames();
    wr(VPT_REG_PORT_BASE, 32'h0005_0f00);
    wr(8'h18, 32'h0005_0f00);
    wr(8'h1c, 32'h0123_0f02);
    vt(12'h005, 4'hf);
    vt(12'h123, 4'hf);
    slow = 1'b1;
    mk(32'h0800_4500);
    ex = fr[0:11];
    ex = {ex, 8'h81, 8'h00, 8'h00, 8'h05, fr[12:17]};
    xfer(2'h0, 2'h1, 1'b0);
    ex = fr;
    xfer(2'h0, 2'h2, 1'b0);
    ex = {fr[0:11], 8'h81, 8'h00, 8'h01, 8'h23, fr[12:17]};
    xfer(2'h3, 2'h1, 1'b0);
    slow = 1'b0;
    mk(32'h8100_0007);
    ex = fr[0:11];
    xfer(2'h1, 2'h3, 1'b1);
    vt(12'h007, 4'hf);
    ex = fr;
    xfer(2'h1, 2'h3, 1'b0);
    mk(32'h8100_0001);
    ex = fr;
    xfer(2'h1, 2'h3, 1'b0);
    mk(32'h8100_0005);
    ex = {fr[0:11], fr[16:17]};
    xfer(2'h1, 2'h0, 1'b0);
  endtask
  // Management filter, then port-based grouping
  task automatic t_filters();
    wr(VPT_REG_CTRL, 32'h0005_0001);
    i_in_mgmt <= 1'b1;
    mk(32'h0800_4500);
    ex = fr;
    xfer(2'h0, 2'h0, 1'b0);
    ex = fr[0:11];
    xfer(2'h3, 2'h0, 1'b1);
    i_in_mgmt <= 1'b0;
    wr(VPT_REG_CTRL, 32'h0000_0000);
    wr(VPT_REG_PORT_BASE, 32'h0005_0000);
    xfer(2'h0, 2'h2, 1'b1);
    mk(32'h8100_0007);
    ex = fr;
    xfer(2'h2, 2'h0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset, timeout and main sequence
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  initial begin
    {i_nrst, i_wr, i_rd, i_in_valid, i_in_sof, i_in_eof, i_in_mgmt, slow} = '0;
    {i_addr, i_in_data, i_wdata, i_in_src, i_in_dst} = '0;
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_mode();
    t_regs();
    t_frames();
    t_filters();
    results();
  end
endmodule

/* File: vpt_pkg.sv */
// Package of constants and types for the VLAN port tagging block
package vpt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int VPT_NPORT  = 4;
  localparam int VPT_PW     = 2;
  localparam int VPT_VID_W  = 12;
  localparam int VPT_DEPTH  = 4096;
  localparam int VPT_BEAT_W = 13;
  localparam int VPT_INJ_N  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] VPT_REG_CTRL      = 8'h00;
  localparam logic [7:0] VPT_REG_STATUS    = 8'h04;
  localparam logic [7:0] VPT_REG_VT_ADDR   = 8'h08;
  localparam logic [7:0] VPT_REG_VT_DATA   = 8'h0c;
  localparam logic [7:0] VPT_REG_PORT_BASE = 8'h10;
  localparam logic [7:0] VPT_REG_STRIDE    = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int VPT_CTRL_MODE_BIT = 0;
  localparam int VPT_CTRL_GVRP_BIT = 1;
  localparam int VPT_CTRL_MVID_LSB = 16;
  localparam int VPT_PORT_TYPE_LSB = 0;
  localparam int VPT_PORT_GRP_LSB  = 8;
  localparam int VPT_PORT_PORT_DEFAULT_VLAN_ID_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and frame constants
  localparam logic [11:0] VPT_VID_DEFAULT  = 12'h001;
  localparam logic [11:0] VPT_VID_MAX      = 12'hffe;
  localparam logic [11:0] VPT_MGMT_VID_RST = 12'h000;
  localparam logic        VPT_MODE_Q_RST   = 1'h1;
  localparam logic [3:0]  VPT_GRP_RST      = 4'hf;
  localparam logic [7:0]  VPT_TPID_HI      = 8'h81;
  localparam logic [7:0]  VPT_TPID_LO      = 8'h00;
  localparam logic [3:0]  VPT_ADDR_LAST    = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    LT_ACCESS,
    LT_TRUNK,
    LT_HYBRID,
    LT_RSVD
  } vpt_link_type;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_TYPE0,
    ST_TYPE1,
    ST_TCI0,
    ST_TCI1,
    ST_LOOK,
    ST_INJ,
    ST_PASS,
    ST_DROP
  } vpt_state_type;

endpackage

/* File: vpt_station.sv */
// Far-end station model: frame sink with optional stalls
`timescale 1ns/1ps
module vpt_station (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Beats from the framer
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_eof,
  input  wire logic       i_err,
  input  wire logic       i_sof,
  input  wire logic [1:0] i_port,
  // Stall control
  input  wire logic       i_slow,
  output logic            o_ready
);
  logic [7:0] q[$];
  logic       got_err = 1'b0;
  int         frames  = 0;
  int         sofs    = 0;
  logic [1:0] port    = 2'h0;
  logic [1:0] ph_r;
  ////////////////////////////////////////////////////////////////////////////
  // Ready low two cycles in three when slow
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ph_r    <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      ph_r    <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      o_ready <= !i_slow || (ph_r == 2'h0);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Collect beats taken at the coming edge
  always @(negedge i_clk) begin
    if (i_valid && o_ready) begin
      if (i_sof) begin
        sofs++;
        port = i_port;
      end
      if (i_err) got_err = 1'b1;
      else q.push_back(i_data);
      if (i_eof) frames++;
    end
  end
endmodule

/* File: vpt_top.sv */
// VLAN port tagging framer: per-port tag insertion, removal and filtering
// Summary of operation
// - Each port has a link type: access, trunk or hybrid; it steers handling.
// - Untagged frame entering access port gets four-byte tag carrying port default VID.
// - Tagged frame leaving access port with matching default VID loses its tag.
// - Access ports sharing a default VID form one group and exchange frames.
// - Trunk port forwards tagged frames only when VID is in its list.
// - Trunk port has no default VID; an untagged frame entering it is given VLAN 1.
// - Trunk port always forwards VLAN 1 frames.
// - Hybrid port combines access handling and tagged list forwarding.
// - Hybrid port always forwards VLAN 1 frames.
// - Default VID settable on access and hybrid ports only, range 1 to 4094; a write with the reserved type code still sets it on a trunk port.
// - Tagged list settable for trunk and hybrid use, entries 1 to 4094.
// - In tag-based mode, nonzero management VID admits management only from ports with that VID.
// - GVRP enable can be set only in tag-based VLAN mode.
// - Entering tag-based mode puts every port in VLAN 1, which stays.
// - Port-based mode ignores tags and confines non-management frames to port groups.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module vpt_top
  import vpt_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Frame input
  input  wire logic        i_in_valid,
  output logic             o_in_ready,
  input  wire logic [7:0]  i_in_data,
  input  wire logic        i_in_sof,
  input  wire logic        i_in_eof,
  input  wire logic [1:0]  i_in_src,
  input  wire logic [1:0]  i_in_dst,
  input  wire logic        i_in_mgmt,
  // Frame output
  output logic             o_out_valid,
  input  wire logic        i_out_ready,
  output logic      [7:0]  o_out_data,
  output logic             o_out_sof,
  output logic             o_out_eof,
  output logic             o_out_err,
  output logic      [1:0]  o_out_port,
  // Mode outputs
  output logic             o_mode_q,
  output logic             o_gvrp_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic vid_ok(input logic [11:0] v);
    vid_ok = (v != 12'h000) && (v <= VPT_VID_MAX);
  endfunction

  function automatic logic port_ok(input vpt_link_type t, input logic [11:0] port_default_vlan_id,
                                   input logic [11:0] vid, input logic member);
    logic in_list;
    in_list = (vid == VPT_VID_DEFAULT) || member;
    case (t)
      LT_ACCESS: port_ok = (vid == port_default_vlan_id);
      LT_TRUNK:  port_ok = in_list;
      LT_HYBRID: port_ok = (vid == port_default_vlan_id) || in_list;
      default:   port_ok = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  vpt_vt_if vt ();

  vpt_state_type state_r, state_nxt;
  logic [3:0]    cnt_r, cnt_nxt;
  logic [1:0]    src_r, src_nxt, dst_r, dst_nxt;
  logic          mgmt_r, mgmt_nxt, tag_in_r, tag_in_nxt;
  logic [11:0]   vid_r, vid_nxt;
  logic [7:0]    b0_r, b0_nxt, b1_r, b1_nxt, c0_r, c0_nxt, c1_r, c1_nxt;
  logic [7:0]    inj_r [VPT_INJ_N];
  logic [7:0]    inj_nxt [VPT_INJ_N];
  logic [2:0]    inj_len_r, inj_len_nxt, inj_idx_r, inj_idx_nxt;
  logic [15:0]   fwd_cnt_r, fwd_cnt_nxt, drop_cnt_r, drop_cnt_nxt;

  logic          mode_q_r, mode_q_nxt, gvrp_r, gvrp_nxt;
  logic [11:0]   mgmt_vid_r, mgmt_vid_nxt, vt_addr_r, vt_addr_nxt;
  vpt_link_type  ptype_r [VPT_NPORT];
  vpt_link_type  ptype_nxt [VPT_NPORT];
  logic [11:0]   port_default_vlan_id_r [VPT_NPORT];
  logic [11:0]   port_default_vlan_id_nxt [VPT_NPORT];
  logic [3:0]    grp_r [VPT_NPORT];
  logic [3:0]    grp_nxt [VPT_NPORT];
  logic [31:0]   rdata_r, rdata_nxt;

  logic [VPT_BEAT_W-1:0] buf_r [2];
  logic [VPT_BEAT_W-1:0] buf_nxt [2];
  logic [1:0]    buf_cnt_r, buf_cnt_nxt;
  logic          room, acc, take, push, pop;
  logic [VPT_BEAT_W-1:0] beat;
  logic          src_ok, dst_ok, mgmt_ok, keep, strip, out_tag;
  vpt_link_type  new_type;

  vpt_vlan_mem u_mem (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .vt     (vt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding decision
  assign src_ok  = port_ok(ptype_r[src_r], port_default_vlan_id_r[src_r], vid_r, vt.rd_data[src_r]);
  assign dst_ok  = port_ok(ptype_r[dst_r], port_default_vlan_id_r[dst_r], vid_r, vt.rd_data[dst_r]);
  assign mgmt_ok = (mgmt_vid_r == 12'h000) || (port_default_vlan_id_r[src_r] == mgmt_vid_r);
  assign keep    = mode_q_r ? (src_ok && (mgmt_r ? mgmt_ok : dst_ok))
                            : (mgmt_r || grp_r[src_r][dst_r]);
  assign strip   = (ptype_r[dst_r] != LT_TRUNK) && (vid_r == port_default_vlan_id_r[dst_r]);
  assign out_tag = mode_q_r && (mgmt_r ? tag_in_r : !strip);

  ////////////////////////////////////////////////////////////////////////////
  // Frame state machine
  assign room = (buf_cnt_r != 2'd2);
  assign acc  = room && !vt.busy && (state_r != ST_LOOK) && (state_r != ST_INJ);
  assign take = acc && i_in_valid;
  assign o_in_ready = acc;

  always_comb begin
    state_nxt = state_r;   cnt_nxt = cnt_r;       src_nxt = src_r;
    dst_nxt = dst_r;       mgmt_nxt = mgmt_r;     tag_in_nxt = tag_in_r;
    vid_nxt = vid_r;       b0_nxt = b0_r;         b1_nxt = b1_r;
    c0_nxt = c0_r;         c1_nxt = c1_r;         inj_nxt = inj_r;
    inj_len_nxt = inj_len_r; inj_idx_nxt = inj_idx_r;
    fwd_cnt_nxt = fwd_cnt_r; drop_cnt_nxt = drop_cnt_r;
    push = 1'b0;
    beat = {dst_r, 1'b1, 1'b1, 1'b0, i_in_data};
    vt.rd_en = 1'b0;
    vt.rd_addr = vid_r;
    case (state_r)
      ST_IDLE: begin
        if (take && i_in_sof) begin
          src_nxt = i_in_src;
          dst_nxt = i_in_dst;
          mgmt_nxt = i_in_mgmt;
          push = 1'b1;
          beat = {i_in_dst, i_in_eof, i_in_eof, 1'b1, i_in_data};
          cnt_nxt = 4'h1;
          state_nxt = i_in_eof ? ST_IDLE : ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (take) begin
          push = 1'b1;
          beat = {dst_r, i_in_eof, i_in_eof, 1'b0, i_in_data};
          cnt_nxt = cnt_r + 4'h1;
          if (i_in_eof) begin
            state_nxt = ST_IDLE;
          end else if (cnt_r == VPT_ADDR_LAST) begin
            state_nxt = ST_TYPE0;
          end
        end
      end
      ST_TYPE0, ST_TYPE1, ST_TCI0, ST_TCI1: begin
        if (take && i_in_eof) begin
          push = 1'b1;
          state_nxt = ST_IDLE;
        end else if (take) begin
          case (state_r)
            ST_TYPE0: begin
              b0_nxt = i_in_data;
              state_nxt = ST_TYPE1;
            end
            ST_TYPE1: begin
              b1_nxt = i_in_data;
              tag_in_nxt = mode_q_r && (b0_r == VPT_TPID_HI) && (i_in_data == VPT_TPID_LO);
              if (tag_in_nxt) begin
                state_nxt = ST_TCI0;
              end else begin
                vid_nxt = (ptype_r[src_r] == LT_TRUNK) ? VPT_VID_DEFAULT : port_default_vlan_id_r[src_r];
                vt.rd_en = 1'b1;
                vt.rd_addr = vid_nxt;
                state_nxt = ST_LOOK;
              end
            end
            ST_TCI0: begin
              c0_nxt = i_in_data;
              state_nxt = ST_TCI1;
            end
            default: begin
              c1_nxt = i_in_data;
              vid_nxt = {c0_r[3:0], i_in_data};
              vt.rd_en = 1'b1;
              vt.rd_addr = vid_nxt;
              state_nxt = ST_LOOK;
            end
          endcase
        end
      end
      ST_LOOK: begin
        inj_idx_nxt = 3'd0;
        if (!tag_in_r && out_tag) begin
          inj_nxt = '{VPT_TPID_HI, VPT_TPID_LO, {4'h0, vid_r[11:8]}, vid_r[7:0],
                      b0_r, b1_r};
          inj_len_nxt = 3'd6;
        end else if (!tag_in_r) begin
          inj_nxt[0] = b0_r;
          inj_nxt[1] = b1_r;
          inj_len_nxt = 3'd2;
        end else if (out_tag) begin
          inj_nxt[0] = b0_r;
          inj_nxt[1] = b1_r;
          inj_nxt[2] = c0_r;
          inj_nxt[3] = c1_r;
          inj_len_nxt = 3'd4;
        end else begin
          inj_len_nxt = 3'd0;
        end
        if (keep) begin
          fwd_cnt_nxt = fwd_cnt_r + 16'h0001;
          state_nxt = (!tag_in_r || out_tag) ? ST_INJ : ST_PASS;
        end else begin
          drop_cnt_nxt = drop_cnt_r + 16'h0001;
          state_nxt = ST_DROP;
        end
      end
      ST_INJ: begin
        if (room) begin
          push = 1'b1;
          beat = {dst_r, 1'b0, 1'b0, 1'b0, inj_r[inj_idx_r]};
          inj_idx_nxt = inj_idx_r + 3'd1;
          if (inj_idx_r == inj_len_r - 3'd1) begin
            state_nxt = ST_PASS;
          end
        end
      end
      ST_PASS: begin
        if (take) begin
          push = 1'b1;
          beat = {dst_r, 1'b0, i_in_eof, 1'b0, i_in_data};
          state_nxt = i_in_eof ? ST_IDLE : ST_PASS;
        end
      end
      ST_DROP: begin
        if (take && i_in_eof) begin
          push = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;  cnt_r <= 4'h0;     src_r <= 2'h0;    dst_r <= 2'h0;
      mgmt_r <= 1'b0;      tag_in_r <= 1'b0;  vid_r <= 12'h000;
      b0_r <= 8'h00;       b1_r <= 8'h00;     c0_r <= 8'h00;    c1_r <= 8'h00;
      inj_r <= '{default: 8'h00};
      inj_len_r <= 3'd0;   inj_idx_r <= 3'd0;
      fwd_cnt_r <= 16'h0000; drop_cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt; cnt_r <= cnt_nxt; src_r <= src_nxt; dst_r <= dst_nxt;
      mgmt_r <= mgmt_nxt;  tag_in_r <= tag_in_nxt; vid_r <= vid_nxt;
      b0_r <= b0_nxt;      b1_r <= b1_nxt;    c0_r <= c0_nxt;   c1_r <= c1_nxt;
      inj_r <= inj_nxt;
      inj_len_r <= inj_len_nxt; inj_idx_r <= inj_idx_nxt;
      fwd_cnt_r <= fwd_cnt_nxt; drop_cnt_r <= drop_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer
  assign pop         = (buf_cnt_r != 2'd0) && i_out_ready;
  assign o_out_valid = (buf_cnt_r != 2'd0);
  assign {o_out_port, o_out_err, o_out_eof, o_out_sof, o_out_data} = buf_r[0];

  always_comb begin
    buf_nxt = buf_r;
    buf_cnt_nxt = buf_cnt_r;
    if (pop) begin
      buf_nxt[0] = buf_r[1];
      buf_cnt_nxt = buf_cnt_r - 2'd1;
    end
    if (push) begin
      buf_nxt[buf_cnt_nxt[0]] = beat;
      buf_cnt_nxt = buf_cnt_nxt + 2'd1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      buf_r <= '{default: '0};
      buf_cnt_r <= 2'd0;
    end else begin
      buf_r <= buf_nxt;
      buf_cnt_r <= buf_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_comb begin
    mode_q_nxt = mode_q_r;  gvrp_nxt = gvrp_r;
    mgmt_vid_nxt = mgmt_vid_r; vt_addr_nxt = vt_addr_r;
    ptype_nxt = ptype_r;    port_default_vlan_id_nxt = port_default_vlan_id_r;   grp_nxt = grp_r;
    rdata_nxt = 32'h0000_0000;
    new_type = vpt_link_type'(i_wdata[VPT_PORT_TYPE_LSB +: 2]);
    vt.wr_en = 1'b0;
    vt.wr_addr = vt_addr_r;
    vt.wr_data = i_wdata[3:0];
    if (i_wr) begin
      if (i_addr == VPT_REG_CTRL) begin
        mode_q_nxt = i_wdata[VPT_CTRL_MODE_BIT];
        gvrp_nxt = i_wdata[VPT_CTRL_GVRP_BIT] && i_wdata[VPT_CTRL_MODE_BIT];
        if (i_wdata[VPT_CTRL_MVID_LSB +: 12] <= VPT_VID_MAX) begin
          mgmt_vid_nxt = i_wdata[VPT_CTRL_MVID_LSB +: 12];
        end
        if (i_wdata[VPT_CTRL_MODE_BIT] && !mode_q_r) begin
          ptype_nxt = '{default: LT_ACCESS};
          port_default_vlan_id_nxt = '{default: VPT_VID_DEFAULT};
        end
      end else if (i_addr == VPT_REG_VT_ADDR) begin
        vt_addr_nxt = i_wdata[11:0];
      end else if (i_addr == VPT_REG_VT_DATA) begin
        vt.wr_en = vid_ok(vt_addr_r);
      end
      for (int p = 0; p < VPT_NPORT; p++) begin
        if (i_addr == VPT_REG_PORT_BASE + 8'(p) * VPT_REG_STRIDE) begin
          if (new_type != LT_RSVD) begin
            ptype_nxt[p] = new_type;
          end
          if ((new_type != LT_TRUNK) && vid_ok(i_wdata[VPT_PORT_PORT_DEFAULT_VLAN_ID_LSB +: 12])) begin
            port_default_vlan_id_nxt[p] = i_wdata[VPT_PORT_PORT_DEFAULT_VLAN_ID_LSB +: 12];
          end
          grp_nxt[p] = i_wdata[VPT_PORT_GRP_LSB +: 4];
        end
      end
    end
    if (i_rd) begin
      if (i_addr == VPT_REG_CTRL) begin
        rdata_nxt = {4'h0, mgmt_vid_r, 13'h0000, vt.busy, gvrp_r, mode_q_r};
      end else if (i_addr == VPT_REG_STATUS) begin
        rdata_nxt = {drop_cnt_r, fwd_cnt_r};
      end else if (i_addr == VPT_REG_VT_ADDR) begin
        rdata_nxt = {20'h00000, vt_addr_r};
      end
      for (int p = 0; p < VPT_NPORT; p++) begin
        if (i_addr == VPT_REG_PORT_BASE + 8'(p) * VPT_REG_STRIDE) begin
          rdata_nxt = {4'h0, port_default_vlan_id_r[p], 4'h0, grp_r[p], 6'h00, ptype_r[p]};
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q_r <= VPT_MODE_Q_RST; gvrp_r <= 1'b0;
      mgmt_vid_r <= VPT_MGMT_VID_RST; vt_addr_r <= 12'h000;
      ptype_r <= '{default: LT_ACCESS};
      port_default_vlan_id_r <= '{default: VPT_VID_DEFAULT};
      grp_r <= '{default: VPT_GRP_RST};
      rdata_r <= 32'h0000_0000;
    end else begin
      mode_q_r <= mode_q_nxt; gvrp_r <= gvrp_nxt;
      mgmt_vid_r <= mgmt_vid_nxt; vt_addr_r <= vt_addr_nxt;
      ptype_r <= ptype_nxt; port_default_vlan_id_r <= port_default_vlan_id_nxt; grp_r <= grp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata   = rdata_r;
  assign o_mode_q  = mode_q_r;
  assign o_gvrp_en = gvrp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_decide;
    state_r == ST_LOOK && mode_q_r && !mgmt_r;
  endsequence

  chk_link_type_legal: assert property (ptype_r[0] != LT_RSVD && ptype_r[1] != LT_RSVD
    && ptype_r[2] != LT_RSVD && ptype_r[3] != LT_RSVD)
    else $error("link type holds reserved code");
  chk_ingress_tag_insert: assert property (s_decide ##0 (!tag_in_r && out_tag && keep) |=>
    (inj_r[0] == VPT_TPID_HI && inj_r[2] == {4'h0, vid_r[11:8]} && inj_r[3] == vid_r[7:0]
     && inj_len_r == 3'd6 && state_r == ST_INJ))
    else $error("inserted tag wrong");
  chk_egress_strip: assert property (s_decide ##0 (tag_in_r && keep
    && ptype_r[dst_r] == LT_ACCESS && vid_r == port_default_vlan_id_r[dst_r]) |=>
    (state_r == ST_PASS && inj_len_r == 3'd0))
    else $error("tag not removed on access egress");
  chk_trunk_filter: assert property (s_decide ##0 (ptype_r[dst_r] == LT_TRUNK
    && vid_r != VPT_VID_DEFAULT && !vt.rd_data[dst_r]) |=> state_r == ST_DROP)
    else $error("trunk forwarded unlisted vid");
  chk_trunk_no_insert: assert property ($rose(state_r == ST_LOOK) && !tag_in_r
    && ptype_r[src_r] == LT_TRUNK && mode_q_r |-> vid_r == VPT_VID_DEFAULT)
    else $error("trunk ingress took a default vid");
  chk_vlan1_forward: assert property (s_decide ##0 (vid_r == VPT_VID_DEFAULT
    && ptype_r[src_r] != LT_ACCESS && ptype_r[dst_r] != LT_ACCESS) |=> state_r != ST_DROP)
    else $error("vlan 1 dropped");
  chk_port_default_vlan_id_range: assert property (vid_ok(port_default_vlan_id_r[0]) && vid_ok(port_default_vlan_id_r[1])
    && vid_ok(port_default_vlan_id_r[2]) && vid_ok(port_default_vlan_id_r[3]))
    else $error("default vid out of range");
  chk_mgmt_filter: assert property (state_r == ST_LOOK && mode_q_r && mgmt_r
    && mgmt_vid_r != 12'h000 && port_default_vlan_id_r[src_r] != mgmt_vid_r |=> state_r == ST_DROP)
    else $error("management frame admitted from wrong vid");
  chk_gvrp_needs_q: assert property (i_wr && i_addr == VPT_REG_CTRL
    && !i_wdata[VPT_CTRL_MODE_BIT] |=> !gvrp_r ##1 (gvrp_r -> mode_q_r))
    else $error("gvrp enabled outside tag mode");
  chk_port_group: assert property (state_r == ST_LOOK && !mode_q_r && !mgmt_r
    |=> (state_r == ST_DROP) == !grp_r[src_r][dst_r] && inj_len_r != 3'd6)
    else $error("port-based grouping broken");
  chk_buf_hold: assert property (o_out_valid && !i_out_ready |=> o_out_valid
    && $stable(o_out_data) && $stable(o_out_eof))
    else $error("output beat lost under stall");

endmodule

/* File: vpt_vlan_mem.sv */
// Tagged VLAN membership memory, cleared by a sweep after reset
`timescale 1ns/1ps
module vpt_vlan_mem
  import vpt_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Memory port
  vpt_vt_if.mem     vt
);

  logic [3:0]  mem_r [0:VPT_DEPTH-1];
  logic [11:0] clr_addr_r;
  logic [11:0] clr_addr_nxt;
  logic        clr_busy_r;
  logic        clr_busy_nxt;
  logic [3:0]  rd_data_r;
  logic [3:0]  rd_data_nxt;
  logic        we;
  logic [11:0] wa;
  logic [3:0]  wd;

  always_comb begin
    clr_addr_nxt = clr_addr_r;
    clr_busy_nxt = clr_busy_r;
    rd_data_nxt  = vt.rd_en ? mem_r[vt.rd_addr] : rd_data_r;
    we           = clr_busy_r | vt.wr_en;
    wa           = clr_busy_r ? clr_addr_r : vt.wr_addr;
    wd           = clr_busy_r ? 4'h0 : vt.wr_data;
    if (clr_busy_r) begin
      clr_addr_nxt = clr_addr_r + 12'h001;
      if (clr_addr_r == 12'hfff) begin
        clr_busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clr_addr_r <= 12'h000;
      clr_busy_r <= 1'b1;
      rd_data_r  <= 4'h0;
    end else begin
      clr_addr_r <= clr_addr_nxt;
      clr_busy_r <= clr_busy_nxt;
      rd_data_r  <= rd_data_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (we) begin
      mem_r[wa] <= wd;
    end
  end

  assign vt.rd_data = rd_data_r;
  assign vt.busy    = clr_busy_r;

endmodule

/* File: vpt_vt_if.sv */
// Interface between the framer and its VLAN membership memory
`timescale 1ns/1ps
interface vpt_vt_if;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [3:0]  wr_data;
  logic        rd_en;
  logic [11:0] rd_addr;
  logic [3:0]  rd_data;
  logic        busy;

  modport mem (
    input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
    output rd_data, busy
  );
  modport user (
    output wr_en, wr_addr, wr_data, rd_en, rd_addr,
    input  rd_data, busy
  );
endinterface
